// ==== ecsc_pkg.sv ====
// Package for the external core supply control block
package ecsc_pkg;
  // Clock rate and short-to-ground detection time
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STG_TIME_US = 100;
  localparam int unsigned STG_CYCLES = (STG_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STG_W = 24;
  // Sync divider: half period of the step down reference in clock cycles
  localparam logic [7:0] SYNC_HALF_RST = 8'h19;
  // Reset values
  localparam logic EN_RST = 1'b0;
  localparam logic SYNC_RST = 1'b0;
  localparam logic ROT_RST = 1'b0;

  // Sequencer states
  typedef enum logic [2:0] {
    ECSC_OFF,
    ECSC_WAIT_UC,
    ECSC_WAIT_CORE,
    ECSC_INIT,
    ECSC_SAFE_SHUTDOWN_STATE
  } ecsc_state_type;

  // Monitor status flags, sticky
  typedef struct packed {
    logic short_ground;
    logic overvoltage;
    logic undervoltage;
  } ecsc_flags_type;

  // Comparator inputs from the analog monitor
  typedef struct packed {
    logic prereg_ok;
    logic mcu_uc_ok;
    logic core_ov;
    logic core_uv;
  } ecsc_mon_type;
endpackage

// ==== ecsc_sync_gen.sv ====
// Sync square wave generator for the external regulator
`timescale 1ns/1ps
`default_nettype none
module ecsc_sync_gen
  import ecsc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic antiphase,
  input wire logic [7:0] half_period,
  output logic sync_out
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic phase_r;
  logic phase_nxt;
  wire wrap = (cnt_r >= half_period - 8'h01);
  // Reference phase runs always so the sync pin stays aligned
  assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
  assign phase_nxt = wrap ? ~phase_r : phase_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end
  // Equal high and low halves give 50% duty; gated low until enabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_out <= SYNC_RST;
    end else begin
      sync_out <= enable & (phase_nxt ^ antiphase);
    end
  end
endmodule
`default_nettype wire

// ==== ecsc_top.sv ====
// External core supply control: enable sequencing, sync and core monitoring
`timescale 1ns/1ps
`default_nettype none
module ecsc_top
  import ecsc_pkg::*;
#(
  parameter int unsigned STG_LIMIT = STG_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic power_up_req,
  input wire logic ext_core_select_pin,
  input wire logic prereg_ok_pin,
  input wire logic mcu_uc_ok_pin,
  input wire logic core_monitor_ov,
  input wire logic core_monitor_uv,
  input wire logic sync_enable,
  input wire logic sync_antiphase,
  input wire logic [7:0] sync_half_period,
  input wire logic flags_clear,
  output logic ext_core_enable_pin,
  output logic sync_out_pin,
  output logic reset_out_pin,
  output logic vref_start,
  output logic ext_core_selected,
  output logic safe_shutdown_state,
  output ecsc_flags_type mon_flags
);
  // Two-stage synchronisers for all analog and pin inputs
  ecsc_mon_type mon_s1_r;
  ecsc_mon_type mon_s2_r;
  logic sel_s1_r;
  logic sel_s2_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mon_s1_r <= '0;
      mon_s2_r <= '0;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      mon_s1_r <= {prereg_ok_pin, mcu_uc_ok_pin, core_monitor_ov, core_monitor_uv};
      mon_s2_r <= mon_s1_r;
      sel_s1_r <= ext_core_select_pin;
      sel_s2_r <= sel_s1_r;
    end
  end

  ecsc_state_type state_r;
  ecsc_state_type state_nxt;
  logic sel_r;
  logic [STG_W-1:0] stg_cnt_r;
  logic [STG_W-1:0] stg_cnt_nxt;
  ecsc_flags_type flags_nxt;

  // Monitor qualifiers; only the own core input counts, no external reset
  wire mon_active = sel_r && (state_r == ECSC_INIT);
  wire ov_evt = mon_active && mon_s2_r.core_ov;
  wire uv_now = mon_active && mon_s2_r.core_uv;
  wire stg_hit = uv_now && (stg_cnt_r >= STG_LIMIT[STG_W-1:0] - 24'h000001);
  wire up_ok = mon_s2_r.prereg_ok && mon_s2_r.mcu_uc_ok;
  // Open pin reads high through the pull-up; high means option active
  wire sel_sample = sel_s2_r;
  // Value the latch takes this edge, so enable never acts on a stale option
  wire sel_nxt = (state_r == ECSC_WAIT_UC && up_ok) ? sel_sample : sel_r;

  // Short ground counter: runs only while undervoltage persists
  assign stg_cnt_nxt = uv_now ? stg_cnt_r + 24'h000001 : '0;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ECSC_OFF: begin
        if (power_up_req) begin
          state_nxt = ECSC_WAIT_UC;
        end
      end
      ECSC_WAIT_UC: begin
        if (up_ok) begin
          state_nxt = ECSC_WAIT_CORE;
        end
      end
      ECSC_WAIT_CORE: begin
        if (!sel_r || !mon_s2_r.core_uv) begin
          state_nxt = ECSC_INIT;
        end
      end
      ECSC_INIT: begin
        if (ov_evt || stg_hit) begin
          state_nxt = ECSC_SAFE_SHUTDOWN_STATE;
        end else if (!up_ok) begin
          state_nxt = ECSC_WAIT_UC;
        end
      end
      ECSC_SAFE_SHUTDOWN_STATE: begin
        state_nxt = ECSC_SAFE_SHUTDOWN_STATE;
      end
      default: begin
        state_nxt = ECSC_OFF;
      end
    endcase
  end

  // Sticky flags; a set in the clearing cycle wins
  assign flags_nxt.overvoltage = ov_evt | (mon_flags.overvoltage & ~flags_clear);
  assign flags_nxt.undervoltage = uv_now | (mon_flags.undervoltage & ~flags_clear);
  assign flags_nxt.short_ground = stg_hit | (mon_flags.short_ground & ~flags_clear);

  // Enable: on from the core start step while option selected, off in safe_shutdown_state
  wire en_nxt = sel_nxt && (state_nxt == ECSC_WAIT_CORE || state_nxt == ECSC_INIT);
  // Reset output released only in init without core undervoltage
  wire rot_nxt = (state_nxt == ECSC_INIT) && !uv_now;
  // Voltage reference waits for the core monitor when option is used
  wire vref_nxt = (state_nxt == ECSC_INIT);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ECSC_OFF;
      stg_cnt_r <= '0;
      mon_flags <= '0;
    end else begin
      state_r <= state_nxt;
      stg_cnt_r <= stg_cnt_nxt;
      mon_flags <= flags_nxt;
    end
  end

  // Select captured only when leaving toward the core start step
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_core_enable_pin <= EN_RST;
      reset_out_pin <= ROT_RST;
      vref_start <= 1'b0;
      safe_shutdown_state <= 1'b0;
      ext_core_selected <= 1'b0;
    end else begin
      ext_core_enable_pin <= en_nxt;
      reset_out_pin <= rot_nxt;
      vref_start <= vref_nxt;
      safe_shutdown_state <= (state_nxt == ECSC_SAFE_SHUTDOWN_STATE);
      ext_core_selected <= sel_r;
    end
  end

  // Sync generator; gated by software enable, low out of reset
  ecsc_sync_gen u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .enable(sync_enable),
    .antiphase(sync_antiphase),
    .half_period(sync_half_period),
    .sync_out(sync_out_pin)
  );

  // Assertions
  property p_ov_off;
    @(posedge mclk) disable iff (!resetn) ov_evt |=> !ext_core_enable_pin && safe_shutdown_state;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("enable not dropped on ov");
  property p_ov_flag;
    @(posedge mclk) disable iff (!resetn) ov_evt |=> mon_flags.overvoltage;
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("ov flag missing");
  property p_uv_rot;
    @(posedge mclk) disable iff (!resetn) uv_now |=> !reset_out_pin && mon_flags.undervoltage;
  endproperty
  a_uv_rot: assert property (p_uv_rot) else $error("uv reaction missing");
  property p_short_uv;
    @(posedge mclk) disable iff (!resetn) uv_now && !stg_hit && !ov_evt |=> !safe_shutdown_state;
  endproperty
  a_short_uv: assert property (p_short_uv) else $error("early safe_shutdown_state");
  property p_stg;
    @(posedge mclk) disable iff (!resetn) stg_hit |=> safe_shutdown_state && mon_flags.short_ground;
  endproperty
  a_stg: assert property (p_stg) else $error("stg escalation missing");
  property p_cnt;
    @(posedge mclk) disable iff (!resetn) !uv_now |=> stg_cnt_r == '0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("stg counter not cleared");
  property p_en_cause;
    @(posedge mclk) disable iff (!resetn) $rose(ext_core_enable_pin) |-> $past(up_ok) && sel_r;
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("enable without cause");
  property p_sync_off;
    @(posedge mclk) disable iff (!resetn) !sync_enable |=> !sync_out_pin;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync toggles while off");
  property p_sel_hold;
    @(posedge mclk) disable iff (!resetn) state_r == ECSC_INIT |=> $stable(sel_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select resampled");
  property p_vref;
    @(posedge mclk) disable iff (!resetn) $rose(vref_start) && sel_r |-> !$past(mon_s2_r.core_uv);
  endproperty
  a_vref: assert property (p_vref) else $error("vref before core ok");
  c_safe_shutdown_state: cover property (@(posedge mclk) disable iff (!resetn) $rose(safe_shutdown_state));
  c_enable: cover property (@(posedge mclk) disable iff (!resetn) $rose(ext_core_enable_pin));
  c_sync: cover property (@(posedge mclk) disable iff (!resetn) $rose(sync_out_pin));
endmodule
`default_nettype wire

// ==== ecsc_ext_reg.sv ====
// Behavioural model of the external switch mode core regulator
`timescale 1ns/1ps
`default_nettype none
module ecsc_ext_reg (
  input wire logic mclk,
  input wire logic enable,
  input wire logic sync_in,
  input wire logic thermal_off,
  input wire logic over_drive,
  output logic uv,
  output logic ov,
  output var logic [7:0] sync_edges
);
  logic sync_d;
  initial sync_edges = 8'h00;
  // Output sits below threshold while off or in its own thermal stop
  assign uv = !enable || thermal_off;
  // Overdrive is shown even when disabled, so ignoring it gets tested
  assign ov = over_drive;
  // Switching locked to sync rising edges; plain always so the counter may start at zero
  always @(posedge mclk) begin
    sync_d <= sync_in;
    if (sync_in && !sync_d) sync_edges <= sync_edges + 8'h01;
  end
endmodule
`default_nettype wire

// ==== external_core_supply_control_tb.sv ====
// Self-checking bench for the external core supply control block
`timescale 1ns/1ps
`default_nettype none
module external_core_supply_control_tb;
  import ecsc_pkg::*;
  logic mclk, resetn, pup, sel, pre_ok, uc_ok, sync_en, anti, fclr, therm, overd;
  logic [7:0] half;
  logic en, sync, rst_out, vref, selected, fs, uv, ov;
  logic [7:0] edges;
  ecsc_flags_type flags;
  int n_fail = 0, tests_run = 0, cyc = 0, seed = 25050, k, a;
  ecsc_top #(.STG_LIMIT(8)) uut (.mclk(mclk), .resetn(resetn), .power_up_req(pup),
    .ext_core_select_pin(sel), .prereg_ok_pin(pre_ok), .mcu_uc_ok_pin(uc_ok),
    .core_monitor_ov(ov), .core_monitor_uv(uv), .sync_enable(sync_en),
    .sync_antiphase(anti), .sync_half_period(half), .flags_clear(fclr),
    .ext_core_enable_pin(en), .sync_out_pin(sync), .reset_out_pin(rst_out),
    .vref_start(vref), .ext_core_selected(selected), .safe_shutdown_state(fs), .mon_flags(flags));
  ecsc_ext_reg partner (.mclk(mclk), .enable(en), .sync_in(sync), .thermal_off(therm),
    .over_drive(overd), .uv(uv), .ov(ov), .sync_edges(edges));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // Settle past the edge so registered outputs have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Enable follows the latched option once supplies are up
  function automatic logic exp_en(input logic s);
    return s;
  endfunction
  task automatic wait_lvl(input logic v);
    k = 0;
    while (sync !== v && k < 600) begin
      wait_cyc(1);
      k++;
    end
  endtask
  // Reset, then run the power sequence with the option open or strapped
  task automatic bring_up(input logic s);
    resetn <= 1'b0;
    pup <= 1'b0;
    pre_ok <= 1'b0;
    uc_ok <= 1'b0;
    sel <= s;
    sync_en <= 1'b0;
    fclr <= 1'b0;
    therm <= 1'b0;
    overd <= 1'b0;
    wait_cyc(4);
    resetn <= 1'b1;
    wait_cyc(1);
    check({en, sync, rst_out, vref, fs, flags}, 8'h00);
    pup <= 1'b1;
    wait_cyc(1);
    pre_ok <= 1'b1;
    uc_ok <= 1'b1;
    wait_cyc(8);
    check(en, exp_en(s));
    check(selected, s);
    wait_cyc(8);
    if (s) check({vref, rst_out}, 8'h03);
  endtask
  initial begin
    {resetn, pup, sel, pre_ok, uc_ok, sync_en, anti, fclr, therm, overd} = 10'h000;
    half = SYNC_HALF_RST;
    // Option strapped low: monitor ignored, regulator stays off
    bring_up(1'b0);
    overd <= 1'b1;
    wait_cyc(6);
    check({en, fs}, 8'h00);
    bring_up(1'b1);
    // Sync stays quiet until software turns it on
    for (a = 0; a < 20; a++) begin
      wait_cyc(1);
      check(sync, 1'b0);
    end
    for (a = 0; a < 2; a++) begin
      sync_en <= 1'b0;
      anti <= a[0];
      half <= 8'h02 + 8'($unsigned($random(seed)) % 8);
      wait_cyc(2);
      sync_en <= 1'b1;
      // First high may be cut by the enable, so measure from the next full halves
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      check(k, half);
      wait_lvl(1'b0);
      check(k, half);
      // Just after a fall no wrap is due, so flipping the phase shows at once
      anti <= ~anti;
      wait_cyc(1);
      check(sync, 1'b1);
    end
    check(edges != 8'h00, 1'b1);
    // Brief thermal stop: reset low and flag, regulator kept on
    therm <= 1'b1;
    wait_cyc(2 + ($unsigned($random(seed)) % 4));
    therm <= 1'b0;
    wait_cyc(3);
    check({en, rst_out, fs, flags}, 8'h31);
    fclr <= 1'b1;
    wait_cyc(1);
    fclr <= 1'b0;
    wait_cyc(1);
    check(flags, 8'h00);
    // Lasting undervoltage escalates to safe shutdown, held after it ends
    therm <= 1'b1;
    wait_cyc(20);
    therm <= 1'b0;
    wait_cyc(5);
    check({en, fs, flags[2]}, 8'h03);
    // Overvoltage drops the enable at once
    bring_up(1'b1);
    overd <= 1'b1;
    wait_cyc(6);
    check({en, fs, flags[1]}, 8'h03);
    results();
  end
endmodule
`default_nettype wire
